// >>> include/bdc_regs.svh
// Function
// - sync select 0 picks asynchronous clock crossing
// - sync select 1 treats clocks as synchronous
// - request limit is field value plus one
// - request limit taken from first function only
// - one compensation register per PCI interface
// - oscillator field drives compensation oscillator
// - decoder shift adjusts compensation code
// - bias field selects detect reference bias
// - disable bit turns compensation logic off
// - bypass enable substitutes programmed bypass value
// - bypass off: field reads live code
`ifndef BDC_REGS_SVH
`define BDC_REGS_SVH

// ----------------------------------------
// register offsets within one function
// ----------------------------------------
`define BDC_OFF_XCFG   8'he0
`define BDC_OFF_DCC    8'he4
`define BDC_OFF_MASK   8'hfc
`define BDC_FUNC_LSB   8

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define BDC_XCFG_W     5
`define BDC_XCFG_SYNC  4
`define BDC_XCFG_RST   5'h0f
`define BDC_DCC_W      16
`define BDC_DCC_RST    16'h0000
`define BDC_CODE_W     8

`endif

// >>> include/bdc_pkg.sv
package bdc_pkg;

	// ----------------------------------------
	// encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		BDC_SHIFT_NONE = 2'h0,
		BDC_SHIFT_UP1  = 2'h1,
		BDC_SHIFT_UP2  = 2'h2,
		BDC_SHIFT_DN1  = 2'h3
	} bdc_shift_t;

	typedef enum logic [1:0] {
		BDC_RESP_OKAY   = 2'h0,
		BDC_RESP_SLVERR = 2'h2
	} bdc_resp_t;

	// ----------------------------------------
	// register layouts, msb first
	// ----------------------------------------
	typedef struct packed {
		logic       sync_sel;  // bit 4
		logic [3:0] req_limit; // bits 3:0
	} bdc_xcfg_t;

	typedef struct packed {
		logic [1:0] osc;       // bits 15:14
		bdc_shift_t shift;     // bits 13:12
		logic [1:0] bias;      // bits 11:10
		logic       dis;       // bit 9
		logic       byp_en;    // bit 8
		logic [7:0] byp_val;   // bits 7:0
	} bdc_dcc_t;

	// per-interface drive toward the buffer compensation
	typedef struct packed {
		logic [1:0] osc;
		logic [1:0] bias;
		logic       comp_en;
		logic [7:0] code;
	} bdc_comp_out_t;

endpackage

// >>> hdl/bdc_cfg.sv
`timescale 1ns/1ps
`include "bdc_regs.svh"

module bdc_cfg #(
	parameter int NUM_IF = 2
) (
	input  wire logic                                    ref_clk,
	input  wire logic                                    rst_n,
	input  wire logic                                    ce,
	input  wire logic [`BDC_FUNC_LSB+$clog2(NUM_IF)-1:0] s_axi_awaddr,
	input  wire logic [2:0]                              s_axi_awprot,
	input  wire logic                                    s_axi_awvalid,
	output wire logic                                    s_axi_awready,
	input  wire logic [31:0]                             s_axi_wdata,
	input  wire logic [3:0]                              s_axi_wstrb,
	input  wire logic                                    s_axi_wvalid,
	output wire logic                                    s_axi_wready,
	output bdc_pkg::bdc_resp_t                           s_axi_bresp,
	output logic                                         s_axi_bvalid,
	input  wire logic                                    s_axi_bready,
	input  wire logic [`BDC_FUNC_LSB+$clog2(NUM_IF)-1:0] s_axi_araddr,
	input  wire logic [2:0]                              s_axi_arprot,
	input  wire logic                                    s_axi_arvalid,
	output wire logic                                    s_axi_arready,
	output logic [31:0]                                  s_axi_rdata,
	output bdc_pkg::bdc_resp_t                           s_axi_rresp,
	output logic                                         s_axi_rvalid,
	input  wire logic                                    s_axi_rready,
	input  wire logic [NUM_IF-1:0][`BDC_CODE_W-1:0]      comp_live_code,
	output wire bdc_pkg::bdc_comp_out_t [NUM_IF-1:0]     comp_out,
	output wire logic [NUM_IF-1:0]                       pci_clk_sync_select,
	output wire logic [NUM_IF-1:0]                       async_path_sel,
	input  wire logic                                    req_issue,
	input  wire logic                                    req_done,
	output wire logic                                    req_allow,
	output wire logic [4:0]                              req_limit_count,
	output logic [4:0]                                   req_outstanding
);
	import bdc_pkg::*;

	localparam int FSEL_W = $clog2(NUM_IF);
	localparam int ADDR_W = `BDC_FUNC_LSB + FSEL_W;

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// decoder shift with saturation at both ends
	function automatic logic [7:0] shift_code(input logic [7:0] c, input bdc_shift_t s);
		logic [8:0] t;
		t = {1'b0, c};
		case (s)
			BDC_SHIFT_UP1: t = t + 9'h001;
			BDC_SHIFT_UP2: t = t + 9'h002;
			BDC_SHIFT_DN1: t = (c == 8'h00) ? 9'h000 : t - 9'h001;
			default:       t = {1'b0, c};
		endcase
		shift_code = t[8] ? 8'hff : t[7:0];
	endfunction

	// byte-lane merge for a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
	                                        input logic [1:0] st);
		merge16 = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	bdc_xcfg_t            xcfg_r     [NUM_IF];
	bdc_dcc_t             dcc_r      [NUM_IF];
	logic [7:0]           live_s1_r  [NUM_IF];
	logic [7:0]           live_s2_r  [NUM_IF];
	bdc_comp_out_t        comp_out_r [NUM_IF];
	logic [NUM_IF-1:0]    async_r;
	logic                 aw_held_r;
	logic [ADDR_W-1:0]    aw_addr_r;
	logic                 w_held_r;
	logic [31:0]          w_data_r;
	logic [3:0]           w_strb_r;
	logic                 do_wr;
	logic [FSEL_W-1:0]    wr_func;
	logic [7:0]           wr_off;
	logic                 wr_hit;
	logic [FSEL_W-1:0]    rd_func;
	logic [7:0]           rd_off;
	logic                 rd_hit;
	logic [31:0]          rd_word;
	logic                 ar_take;
	logic                 req_inc;
	logic                 req_dec;

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	assign s_axi_awready = ce & ~aw_held_r;
	assign s_axi_wready  = ce & ~w_held_r;
	assign do_wr         = ce & aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wr_func       = aw_addr_r[ADDR_W-1:`BDC_FUNC_LSB];
	assign wr_off        = aw_addr_r[7:0] & `BDC_OFF_MASK;
	assign wr_hit        = (32'(wr_func) < NUM_IF) && (wr_off == `BDC_OFF_XCFG || wr_off == `BDC_OFF_DCC);

	// address and data are caught independently, in either order
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (do_wr) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// write response, error for unmapped offsets
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= BDC_RESP_OKAY;
		end else if (ce) begin
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? BDC_RESP_OKAY : BDC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// per-interface registers and compensation drive
	// ----------------------------------------
	for (genvar i = 0; i < NUM_IF; i++) begin : g_if
		logic wr_xcfg;
		logic wr_dcc;
		assign wr_xcfg = do_wr && (32'(wr_func) == i) && (wr_off == `BDC_OFF_XCFG);
		assign wr_dcc  = do_wr && (32'(wr_func) == i) && (wr_off == `BDC_OFF_DCC);

		// extra config copy of this function, low byte only implemented
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				xcfg_r[i] <= bdc_xcfg_t'(`BDC_XCFG_RST);
			end else if (ce && wr_xcfg && w_strb_r[0]) begin
				xcfg_r[i] <= bdc_xcfg_t'(w_data_r[`BDC_XCFG_W-1:0]);
			end
		end

		// compensation control of this interface only
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				dcc_r[i] <= bdc_dcc_t'(`BDC_DCC_RST);
			end else if (ce && wr_dcc) begin
				dcc_r[i] <= bdc_dcc_t'(merge16(dcc_r[i], w_data_r[`BDC_DCC_W-1:0], w_strb_r[1:0]));
			end
		end

		// live code comes from the analog circuit, two-stage synchroniser
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				live_s1_r[i] <= 8'h00;
				live_s2_r[i] <= 8'h00;
			end else if (ce) begin
				live_s1_r[i] <= comp_live_code[i];
				live_s2_r[i] <= live_s1_r[i];
			end
		end

		// registered drive toward the buffers
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				comp_out_r[i] <= '0;
			end else if (ce) begin
				comp_out_r[i].osc     <= dcc_r[i].osc;
				comp_out_r[i].bias    <= dcc_r[i].bias;
				comp_out_r[i].comp_en <= ~dcc_r[i].dis;
				comp_out_r[i].code    <= dcc_r[i].byp_en ? dcc_r[i].byp_val
				                                         : shift_code(live_s2_r[i], dcc_r[i].shift);
			end
		end

		// clock crossing path select
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				async_r[i] <= 1'b1;
			end else if (ce) begin
				async_r[i] <= ~xcfg_r[i].sync_sel;
			end
		end

		assign comp_out[i]            = comp_out_r[i];
		assign pci_clk_sync_select[i] = ~async_r[i];
		assign async_path_sel[i]      = async_r[i];

		async_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			ce && !xcfg_r[i].sync_sel |=> async_path_sel[i] && !pci_clk_sync_select[i])
			else $error("sync select 0 did not pick async path");

		sync_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			ce && xcfg_r[i].sync_sel |=> !async_path_sel[i] && pci_clk_sync_select[i])
			else $error("sync select 1 did not pick sync path");

		osc_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			ce |=> comp_out[i].osc == $past(dcc_r[i].osc) && comp_out[i].bias == $past(dcc_r[i].bias))
			else $error("oscillator or bias drive mismatch");

		shift_up_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			ce && !dcc_r[i].byp_en && dcc_r[i].shift == BDC_SHIFT_UP2 && live_s2_r[i] < 8'hfe
			|=> comp_out[i].code == $past(live_s2_r[i]) + 8'h02)
			else $error("decoder shift by two wrong");

		shift_dn_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			ce && !dcc_r[i].byp_en && dcc_r[i].shift == BDC_SHIFT_DN1 && live_s2_r[i] != 8'h00
			|=> comp_out[i].code == $past(live_s2_r[i]) - 8'h01)
			else $error("decoder shift down wrong");

		comp_dis_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			ce |=> comp_out[i].comp_en == !$past(dcc_r[i].dis))
			else $error("compensation enable does not follow disable bit");

		bypass_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			ce && dcc_r[i].byp_en |=> comp_out[i].code == $past(dcc_r[i].byp_val))
			else $error("bypass value not applied");

		// clock enable low holds the drive and the path select
		comp_freeze_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			!ce |=> $stable(comp_out[i]) && $stable(async_path_sel[i]))
			else $error("compensation drive moved while frozen");
	end

	// writes to one function leave the other untouched
	if (NUM_IF > 1) begin : g_iso
		dcc_isolate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			do_wr && wr_func != '0 |=> $stable(dcc_r[0]) && $stable(xcfg_r[0]))
			else $error("write leaked into first function");

		limit_source_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			$changed(xcfg_r[1].req_limit) && $stable(xcfg_r[0].req_limit) |-> $stable(req_limit_count))
			else $error("limit followed second function");
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	assign s_axi_arready = ce & ~s_axi_rvalid;
	assign ar_take       = s_axi_arvalid & s_axi_arready;
	assign rd_func       = s_axi_araddr[ADDR_W-1:`BDC_FUNC_LSB];
	assign rd_off        = s_axi_araddr[7:0] & `BDC_OFF_MASK;

	// read mux, bypass field shows live code while bypass is off
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b0;
		for (int f = 0; f < NUM_IF; f++) begin
			if (32'(rd_func) == f && rd_off == `BDC_OFF_XCFG) begin
				rd_word = 32'(xcfg_r[f]);
				rd_hit  = 1'b1;
			end
			if (32'(rd_func) == f && rd_off == `BDC_OFF_DCC) begin
				rd_word = {16'h0000, dcc_r[f][15:8], dcc_r[f].byp_en ? dcc_r[f].byp_val : live_s2_r[f]};
				rd_hit  = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= BDC_RESP_OKAY;
		end else if (ce) begin
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_hit ? BDC_RESP_OKAY : BDC_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	live_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ar_take && rd_func == '0 && rd_off == `BDC_OFF_DCC && !dcc_r[0].byp_en
		|=> s_axi_rvalid && s_axi_rdata[7:0] == $past(live_s2_r[0]))
		else $error("bypass field did not read live code");

	wr_resp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		do_wr |=> s_axi_bvalid && !aw_held_r && !w_held_r)
		else $error("write response missing");

	// clock enable low refuses every handshake
	ready_freeze_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready raised while frozen");

	// ----------------------------------------
	// outstanding completion-required requests
	// ----------------------------------------
	assign req_limit_count = {1'b0, xcfg_r[0].req_limit} + 5'h01;
	assign req_allow       = req_outstanding < req_limit_count;
	assign req_inc         = req_issue & req_allow;
	assign req_dec         = req_done & (req_outstanding != 5'h00);

	// count issues allowed by the limit, drain on completion
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			req_outstanding <= 5'h00;
		end else if (ce) begin
			if (req_inc && !req_dec) begin
				req_outstanding <= req_outstanding + 5'h01;
			end else if (req_dec && !req_inc) begin
				req_outstanding <= req_outstanding - 5'h01;
			end
		end
	end

	limit_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && req_issue && req_outstanding >= req_limit_count |=> req_outstanding <= $past(req_outstanding))
		else $error("request issued beyond limit");

	limit_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		xcfg_r[0].req_limit == 4'h0 && req_outstanding == 5'h01 |-> !req_allow)
		else $error("encoding 0 allowed more than one request");

	// clock enable low holds the request count
	count_freeze_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!ce |=> $stable(req_outstanding))
		else $error("request count moved while frozen");

endmodule

// >>> bench/tb_bdc_cfg.sv
`timescale 1ns/1ps
`include "bdc_regs.svh"

module tb_bdc_cfg;
	import bdc_pkg::*;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic                  ref_clk = 1'b0;
	logic                  rst_n   = 1'b0;
	logic                  ce      = 1'b1;
	logic [8:0]            awaddr  = '0;
	logic [8:0]            araddr  = '0;
	logic [31:0]           wdata   = '0;
	logic [3:0]            wstrb   = 4'hf;
	logic                  awvalid = 1'b0;
	logic                  wvalid  = 1'b0;
	logic                  bready  = 1'b0;
	logic                  arvalid = 1'b0;
	logic                  rready  = 1'b0;
	logic [1:0][7:0]       live_code = {8'ha5, 8'h3c};
	logic                  req_issue = 1'b0;
	logic                  req_done  = 1'b0;
	logic                  awready, wready, arready, bvalid, rvalid, req_allow;
	bdc_resp_t             bresp, rresp;
	logic [31:0]           rdata;
	bdc_comp_out_t [1:0]   comp_out;
	logic [1:0]            sync_sel, async_sel;
	logic [4:0]            lim_cnt, outst;
	int                    errors = 0;
	int                    check_count = 0;
	int                    seed = 32'h92a3d03f;

	// free-running 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	bdc_cfg #(.NUM_IF(2)) i_bdc_cfg (
		.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.comp_live_code(live_code), .comp_out(comp_out), .pci_clk_sync_select(sync_sel),
		.async_path_sel(async_sel), .req_issue(req_issue), .req_done(req_done), .req_allow(req_allow),
		.req_limit_count(lim_cnt), .req_outstanding(outst)
	);

	// ----------------------------------------
	// compare, expectation and bus tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_resp(input string what, input bdc_resp_t exp, input bdc_resp_t got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [31:0] exp_lim(input logic [3:0] l);
		return 32'(l) + 32'd1;
	endfunction

	// saturating decoder shift
	function automatic logic [7:0] exp_code(input logic [7:0] c, input logic [1:0] s);
		case (s)
			2'h1: return (c == 8'hff) ? c : c + 8'h1;
			2'h2: return (c >= 8'hfe) ? 8'hff : c + 8'h2;
			2'h3: return (c == 8'h00) ? c : c - 8'h1;
			default: return c;
		endcase
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// address and data offered together, each released when taken
	task automatic wr(input logic [8:0] a, input logic [31:0] d, input bdc_resp_t er);
		bit aw_ok;
		bit w_ok;
		int n;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok) && n < 50) begin
			@(posedge ref_clk);
			n++;
			if (awready === 1'b1) aw_ok = 1'b1;
			if (wready === 1'b1) w_ok = 1'b1;
			awvalid <= !aw_ok;
			wvalid <= !w_ok;
		end
		while (bvalid !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		chk_resp("write response", er, bresp);
		chk("write finished", 32'd1, 32'(n < 50));
		bready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rdc(input string what, input logic [8:0] a, input logic [31:0] ed, input bdc_resp_t er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		chk(what, ed, rdata);
		chk_resp(what, er, rresp);
		rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [3:0]  lim;
		logic [31:0] w;
		logic [7:0]  lv;
		logic [1:0]  sh;
		bit          byp;
		tick(12);
		rst_n <= 1'b1;
		tick(2);
		chk("limit count", 32'd16, 32'(lim_cnt));
		chk("async select", 32'h3, 32'(async_sel));
		chk("sync select", 32'h0, 32'(sync_sel));
		rdc("xcfg f0", 9'(`BDC_OFF_XCFG), 32'h0f, BDC_RESP_OKAY);
		rdc("comp f0 live", 9'(`BDC_OFF_DCC), 32'h3c, BDC_RESP_OKAY);
		rdc("unmapped", 9'h0f0, 32'h0, BDC_RESP_SLVERR);
		wr(9'h0f0, $random(seed), BDC_RESP_SLVERR);
		$display("test reset and map done");
		// second function sync bit set, its limit field must be ignored
		wr(9'h1e0, 32'h10, BDC_RESP_OKAY);
		tick(2);
		chk("sync select", 32'h2, 32'(sync_sel));
		chk("async select", 32'h1, 32'(async_sel));
		chk("limit f1 ignored", 32'd16, 32'(lim_cnt));
		rdc("xcfg f1", 9'h1e0, 32'h10, BDC_RESP_OKAY);
		$display("test clock select done");
		// limit corners then random, fill past limit and drain past zero
		for (int i = 0; i < 5; i++) begin
			lim = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
			wr(9'(`BDC_OFF_XCFG), {28'h0, lim}, BDC_RESP_OKAY);
			tick(2);
			chk("limit count", exp_lim(lim), 32'(lim_cnt));
			req_issue <= 1'b1;
			tick(int'(lim) + 3);
			req_issue <= 1'b0;
			tick(1);
			chk("outstanding", exp_lim(lim), 32'(outst));
			chk("allow full", 32'h0, 32'(req_allow));
			req_done <= 1'b1;
			tick(18);
			req_done <= 1'b0;
			tick(1);
			chk("drained", 32'h0, 32'(outst));
			chk("allow empty", 32'h1, 32'(req_allow));
		end
		$display("test request limit done");
		// every shift code on live code corners, then bypass values
		for (int i = 0; i < 16; i++) begin
			w = $random(seed);
			byp = (i >= 12);
			sh = byp ? 2'h0 : 2'(i);
			lv = (i < 4) ? 8'h00 : (i < 8) ? 8'hff : w[23:16];
			live_code[0] <= lv;
			wr(9'(`BDC_OFF_DCC), {16'h0, w[15:14], sh, w[11:9], byp, w[7:0]}, BDC_RESP_OKAY);
			tick(4);
			chk("comp out f0", {19'h0, w[15:14], w[11:10], ~w[9], byp ? w[7:0] : exp_code(lv, sh)},
				32'(comp_out[0]));
			chk("comp out f1", {19'h0, 5'h1, 8'ha5}, 32'(comp_out[1]));
			rdc("comp readback", 9'(`BDC_OFF_DCC), {16'h0, w[15:14], sh, w[11:9], byp, byp ? w[7:0] : lv},
				BDC_RESP_OKAY);
		end
		$display("test compensation done");
		// clock enable low refuses handshakes and holds the request count
		ce <= 1'b0;
		req_issue <= 1'b1;
		tick(3);
		chk("frozen readies", 32'h0, 32'({awready, wready, arready}));
		chk("frozen count", 32'h0, 32'(outst));
		req_issue <= 1'b0;
		ce <= 1'b1;
		tick(2);
		chk("count after freeze", 32'h0, 32'(outst));
		$display("test clock enable done");
		give_verdict();
	end

	// hang guard, far beyond the expected run length
	initial begin
		#500000;
		errors++;
		give_verdict();
	end

endmodule
